// [hw/hdb_defines.svh]
// Summary of operation
// - Offset 6 holds controller current, 1 mA units
// - Power source bit selects bus or self current
// - Current comes from stored configured fields
// - Offset 7 returns non-removable port mask unchanged
// - Offset 8 returns constant FFh
// - String zero: 04h, 03h, language id
// - Maker string: length plus two, 03h, bytes
// - Product string: length plus two, 03h, bytes
// - Serial string: length plus two, 03h, bytes
// - Each string stores up to 30 characters
// - Charger range on upstream lines sets status
`ifndef HDB_DEFINES_SVH
`define HDB_DEFINES_SVH

// APB register offsets
`define HDB_REG_CTRL      12'h000
`define HDB_REG_BUS_CUR   12'h004
`define HDB_REG_SELF_CUR  12'h008
`define HDB_REG_NRMASK    12'h00C
`define HDB_REG_LANG      12'h010
`define HDB_REG_STRLEN    12'h014
`define HDB_REG_STRWR     12'h018
`define HDB_REG_STATUS    12'h01C
`define HDB_REG_MASK      12'h020
`define HDB_REG_CHG       12'h024

// Control field positions
`define HDB_CTRL_PWRSEL   0

// Status bit positions
`define HDB_ST_CHARGER    0
`define HDB_ST_DONE       1

// Descriptor constants
`define HDB_HUB_HDR_LEN   8'h09
`define HDB_HUB_TYPE      8'h29
`define HDB_STR_TYPE      8'h03
`define HDB_STR0_LEN      8'h04
`define HDB_PWR_MASK      8'hFF
`define HDB_OFS_CURRENT   8'h06
`define HDB_OFS_NRMASK    8'h07
`define HDB_OFS_PWRMASK   8'h08
`define HDB_STR_HDR       8'h02

// Internal defaults
`define HDB_DEF_BUS_CUR   8'h32
`define HDB_DEF_SELF_CUR  8'h01
`define HDB_DEF_NRMASK    8'h00
`define HDB_DEF_LANG      16'h0409
`define HDB_STR_MAX       30

`endif

// [hw/hdb_pkg.sv]
package hdb_pkg;
	typedef enum logic [2:0] {
		HDB_SEL_HUB,
		HDB_SEL_STR0,
		HDB_SEL_MAKER,
		HDB_SEL_PRODUCT,
		HDB_SEL_SERIAL
	} hdb_sel_t;

	typedef enum logic [0:0] {
		HDB_IDLE,
		HDB_SEND
	} hdb_state_t;
endpackage

// [hw/hdb_builder.sv]
`include "hdb_defines.svh"

module hdb_builder
	import hdb_pkg::*;
#(
	parameter int STR_MAX = `HDB_STR_MAX
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Upstream line monitor
	input  wire logic        upstream_line_plus,
	input  wire logic        upstream_line_minus,
	// Descriptor read port
	input  wire logic        desc_req,
	input  wire logic [2:0]  desc_sel,
	input  wire logic [7:0]  desc_req_len,
	input  wire logic        desc_ready,
	output logic             desc_valid,
	output logic [7:0]       desc_data,
	output logic             desc_last,
	output logic             desc_busy,
	output logic             irq
);

	// Stored configuration
	logic       power_source_select_q;
	logic [7:0] bus_ctrl_current_reg_q;
	logic [7:0] self_powered_ctrl_current_q;
	logic [7:0] nonremovable_port_mask_q;
	logic [7:0] language_id_high_q;
	logic [7:0] language_id_low_q;
	logic [4:0] maker_string_length_q;
	logic [4:0] product_string_length_q;
	logic [4:0] serial_string_length_q;
	logic [7:0] maker_string_q   [STR_MAX];
	logic [7:0] product_string_q [STR_MAX];
	logic [7:0] serial_string_q  [STR_MAX];
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic       charger_range_q;

	// Descriptor engine state
	hdb_state_t state_q;
	hdb_sel_t   sel_q;
	logic [7:0] ofs_q;
	logic [7:0] end_q;
	logic [7:0] byte_d;
	logic [7:0] total_len;
	logic [7:0] cur_len;
	logic       done_evt;
	logic [4:0] str_idx;
	logic       status_clr;

	// Writes act in the access phase; reads latch prdata in the setup phase
	logic apb_wr;
	logic apb_rd;
	assign apb_wr  = psel && penable && pwrite;
	assign apb_rd  = psel && penable && !pwrite;
	assign pready  = 1'b1; // Zero wait states: every register is a flop
	assign pslverr = 1'b0;

	// Configuration writes; reset values act as internal defaults
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			power_source_select_q       <= 1'b0;
			bus_ctrl_current_reg_q      <= `HDB_DEF_BUS_CUR;
			self_powered_ctrl_current_q <= `HDB_DEF_SELF_CUR;
			nonremovable_port_mask_q    <= `HDB_DEF_NRMASK;
			language_id_high_q          <= 8'(`HDB_DEF_LANG >> 8);
			language_id_low_q           <= 8'(`HDB_DEF_LANG);
			maker_string_length_q       <= 5'h00;
			product_string_length_q     <= 5'h00;
			serial_string_length_q      <= 5'h00;
			mask_q                      <= 2'b00;
			charger_range_q             <= 1'b0;
		end else if (apb_wr) begin
			if (paddr == `HDB_REG_CTRL) begin
				power_source_select_q <= pwdata[`HDB_CTRL_PWRSEL];
			end else if (paddr == `HDB_REG_BUS_CUR) begin
				bus_ctrl_current_reg_q <= pwdata[7:0];
			end else if (paddr == `HDB_REG_SELF_CUR) begin
				self_powered_ctrl_current_q <= pwdata[7:0];
			end else if (paddr == `HDB_REG_NRMASK) begin
				nonremovable_port_mask_q <= pwdata[7:0];
			end else if (paddr == `HDB_REG_LANG) begin
				language_id_high_q <= pwdata[15:8];
				language_id_low_q  <= pwdata[7:0];
			end else if (paddr == `HDB_REG_STRLEN) begin
				// Lengths above the storage size are clipped to it
				maker_string_length_q   <= (pwdata[7:0] > 8'(STR_MAX)) ?
					5'(STR_MAX) : pwdata[4:0];
				product_string_length_q <= (pwdata[15:8] > 8'(STR_MAX)) ?
					5'(STR_MAX) : pwdata[12:8];
				serial_string_length_q  <= (pwdata[23:16] > 8'(STR_MAX)) ?
					5'(STR_MAX) : pwdata[20:16];
			end else if (paddr == `HDB_REG_MASK) begin
				mask_q <= pwdata[1:0];
			end else if (paddr == `HDB_REG_CHG) begin
				charger_range_q <= pwdata[0];
			end
		end
	end

	// String storage: STRWR takes {sel[17:16], index[12:8], byte[7:0]}
	genvar gi;
	generate
		for (gi = 0; gi < STR_MAX; gi++) begin : g_str
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					maker_string_q[gi]   <= 8'h00;
					product_string_q[gi] <= 8'h00;
					serial_string_q[gi]  <= 8'h00;
				end else if (apb_wr && paddr == `HDB_REG_STRWR &&
						pwdata[12:8] == 5'(gi)) begin
					if (pwdata[17:16] == 2'd0) begin
						maker_string_q[gi] <= pwdata[7:0];
					end else if (pwdata[17:16] == 2'd1) begin
						product_string_q[gi] <= pwdata[7:0];
					end else if (pwdata[17:16] == 2'd2) begin
						serial_string_q[gi] <= pwdata[7:0];
					end
				end
			end
		end
	endgenerate

	// Charger detect: both lines high while charger range is sensed
	logic chg_evt;
	assign chg_evt = charger_range_q && upstream_line_plus && upstream_line_minus;

	// A status read clears only the bits latched into prdata at its setup
	// cycle, so an event landing between setup and access is not lost
	assign status_clr = apb_rd && (paddr == `HDB_REG_STATUS);

	// Sticky status; event wins over the read clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_q <= 2'b00;
		end else begin
			status_q[`HDB_ST_CHARGER] <= chg_evt || (status_q[`HDB_ST_CHARGER] &&
				!(status_clr && prdata[`HDB_ST_CHARGER]));
			status_q[`HDB_ST_DONE] <= done_evt || (status_q[`HDB_ST_DONE] &&
				!(status_clr && prdata[`HDB_ST_DONE]));
		end
	end

	// Level interrupt while any unmasked status bit is set
	assign irq = |(status_q & mask_q);

	// Read data register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == `HDB_REG_CTRL) begin
				prdata <= {31'h0, power_source_select_q};
			end else if (paddr == `HDB_REG_BUS_CUR) begin
				prdata <= {24'h0, bus_ctrl_current_reg_q};
			end else if (paddr == `HDB_REG_SELF_CUR) begin
				prdata <= {24'h0, self_powered_ctrl_current_q};
			end else if (paddr == `HDB_REG_NRMASK) begin
				prdata <= {24'h0, nonremovable_port_mask_q};
			end else if (paddr == `HDB_REG_LANG) begin
				prdata <= {16'h0, language_id_high_q, language_id_low_q};
			end else if (paddr == `HDB_REG_STRLEN) begin
				prdata <= {11'h0, serial_string_length_q, 3'h0,
					product_string_length_q, 3'h0, maker_string_length_q};
			end else if (paddr == `HDB_REG_STATUS) begin
				prdata <= {30'h0, status_q};
			end else if (paddr == `HDB_REG_MASK) begin
				prdata <= {30'h0, mask_q};
			end else if (paddr == `HDB_REG_CHG) begin
				prdata <= {30'h0, desc_busy, charger_range_q};
			end else begin
				prdata <= 32'h0000_0000; // Unmapped reads as zero
			end
		end
	end

	// Full length of the selected descriptor
	always_comb begin
		case (hdb_sel_t'(desc_sel))
			HDB_SEL_HUB:     total_len = `HDB_HUB_HDR_LEN;
			HDB_SEL_STR0:    total_len = `HDB_STR0_LEN;
			HDB_SEL_MAKER:   total_len = 8'(maker_string_length_q) + `HDB_STR_HDR;
			HDB_SEL_PRODUCT: total_len = 8'(product_string_length_q) + `HDB_STR_HDR;
			HDB_SEL_SERIAL:  total_len = 8'(serial_string_length_q) + `HDB_STR_HDR;
			default:         total_len = `HDB_HUB_HDR_LEN;
		endcase
	end

	// Controller current follows present power mode
	assign cur_len = power_source_select_q ? self_powered_ctrl_current_q :
		bus_ctrl_current_reg_q;

	// Length byte of the string descriptor held in sel_q
	function automatic logic [7:0] end_len_full(input hdb_sel_t s);
		logic [4:0] n;
		n = (s == HDB_SEL_MAKER) ? maker_string_length_q :
			(s == HDB_SEL_PRODUCT) ? product_string_length_q : serial_string_length_q;
		return 8'(n) + `HDB_STR_HDR;
	endfunction

	// Byte at the current offset; earlier hub bytes come from elsewhere, read 0
	always_comb begin
		byte_d  = 8'h00;
		str_idx = 5'(ofs_q - 8'h02); // Character index behind the two-byte header
		case (sel_q)
			HDB_SEL_HUB: begin
				if (ofs_q == 8'h00) byte_d = `HDB_HUB_HDR_LEN;
				else if (ofs_q == 8'h01) byte_d = `HDB_HUB_TYPE;
				else if (ofs_q == `HDB_OFS_CURRENT) byte_d = cur_len;
				else if (ofs_q == `HDB_OFS_NRMASK) byte_d = nonremovable_port_mask_q;
				else if (ofs_q == `HDB_OFS_PWRMASK) byte_d = `HDB_PWR_MASK;
			end
			HDB_SEL_STR0: begin
				if (ofs_q == 8'h00) byte_d = `HDB_STR0_LEN;
				else if (ofs_q == 8'h01) byte_d = `HDB_STR_TYPE;
				else if (ofs_q == 8'h02) byte_d = language_id_low_q; // Little endian
				else byte_d = language_id_high_q;
			end
			default: begin
				if (ofs_q == 8'h00) byte_d = end_len_full(sel_q);
				else if (ofs_q == 8'h01) byte_d = `HDB_STR_TYPE;
				// Offset runs one past the last character once idle; keep the
				// array read in range so the data flop never loads unknowns
				else if (32'(str_idx) >= STR_MAX) byte_d = 8'h00;
				else if (sel_q == HDB_SEL_MAKER) byte_d = maker_string_q[str_idx];
				else if (sel_q == HDB_SEL_PRODUCT) byte_d = product_string_q[str_idx];
				else byte_d = serial_string_q[str_idx];
			end
		endcase
	end

	// Descriptor engine: one byte per accepted beat, in offset order
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= HDB_IDLE;
			sel_q   <= HDB_SEL_HUB;
			ofs_q   <= 8'h00;
			end_q   <= 8'h00;
		end else begin
			case (state_q)
				HDB_IDLE: begin
					if (desc_req && desc_req_len != 8'h00) begin
						// Unknown selector codes fall back to the hub descriptor,
						// the same one whose length total_len picks for them
						sel_q   <= (desc_sel > 3'd4) ? HDB_SEL_HUB : hdb_sel_t'(desc_sel);
						ofs_q   <= 8'h00;
						end_q   <= (desc_req_len < total_len) ? desc_req_len :
							total_len;
						state_q <= HDB_SEND;
					end
				end
				HDB_SEND: begin
					// Advance only on an accepted byte; ready alone in a gap
					// cycle must not skip an offset
					if (desc_valid && desc_ready) begin
						ofs_q <= ofs_q + 8'h01;
						if (ofs_q + 8'h01 == end_q) begin
							state_q <= HDB_IDLE;
						end
					end
				end
				default: state_q <= HDB_IDLE;
			endcase
		end
	end

	// Output byte register, refreshed ahead of each beat
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			desc_data <= 8'h00;
		end else begin
			desc_data <= byte_d;
		end
	end

	// Second cycle of a beat: desc_data was loaded on the previous edge
	logic send_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			send_q <= 1'b0;
		end else begin
			send_q <= (state_q == HDB_SEND) && !(desc_valid && desc_ready);
		end
	end

	// Valid once the data flop holds the current offset
	assign desc_valid = (state_q == HDB_SEND) && send_q;
	assign desc_last  = desc_valid && (ofs_q + 8'h01 == end_q);
	assign desc_busy  = (state_q == HDB_SEND);
	assign done_evt   = desc_last && desc_ready;

endmodule

// [tb/hdb_asserts.sv]
module hdb_asserts #(
	parameter int STR_MAX = 30
) (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       desc_req,
	input wire logic [2:0] desc_sel,
	input wire logic [7:0] desc_req_len,
	input wire logic       desc_ready,
	input wire logic       desc_valid,
	input wire logic [7:0] desc_data,
	input wire logic       desc_last,
	input wire logic       desc_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// A request the engine must take
	sequence take_s;
		desc_req && !desc_busy && desc_req_len != 8'h00;
	endsequence
	// One idle cycle, then the next byte
	sequence gap_s;
		!desc_valid ##1 desc_valid;
	endsequence
	start_walk_a: assert property (take_s |=> desc_busy ##0 gap_s)
		else $error("first byte not two cycles after request");
	hub_first_a: assert property ((take_s ##0 desc_sel == 3'd0) |-> ##2 desc_data == 8'h09)
		else $error("hub descriptor length byte wrong");
	str0_first_a: assert property ((take_s ##0 desc_sel == 3'd1) |-> ##2 desc_data == 8'h04)
		else $error("language descriptor length byte wrong");
	byte_hold_a: assert property (desc_valid && !desc_ready |=> desc_valid && $stable(desc_data))
		else $error("byte dropped before acceptance");
	next_byte_a: assert property (desc_valid && desc_ready && !desc_last |=> gap_s)
		else $error("next byte not two cycles after acceptance");
	stop_send_a: assert property (desc_valid && desc_ready && desc_last |=> !desc_valid [*2])
		else $error("bytes sent after final byte");
	last_flag_a: assert property (desc_last |-> desc_valid)
		else $error("final flag without a byte");
	idle_quiet_a: assert property (!desc_busy |-> !desc_valid)
		else $error("byte offered while idle");
	apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
		else $error("register access not answered cleanly");
endmodule

bind hdb_builder hdb_asserts #(.STR_MAX(STR_MAX)) chk_i (.clk, .nrst, .psel, .penable, .pready,
	.pslverr, .desc_req, .desc_sel, .desc_req_len, .desc_ready, .desc_valid, .desc_data,
	.desc_last, .desc_busy);

// [tb/hdb_host.sv]
module hdb_host (
	input  wire logic       clk,
	input  wire logic       desc_valid,
	input  wire logic [7:0] desc_data,
	input  wire logic       desc_last,
	output logic            desc_req,
	output logic      [2:0] desc_sel,
	output logic      [7:0] desc_req_len,
	output logic            desc_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	initial begin
		desc_req = 1'b0;
		desc_sel = 3'd0;
		desc_req_len = 8'h00;
		desc_ready = 1'b0;
	end
	// Slow mode stalls acceptance at random to exercise holding
	task automatic fetch(input logic [2:0] s, input logic [7:0] n, input bit slow);
		bit done;
		done = 0;
		got.delete();
		@(posedge clk);
		desc_sel <= s;
		desc_req_len <= n;
		desc_req <= 1'b1;
		@(posedge clk);
		desc_req <= 1'b0;
		for (int i = 0; i < 300 && !done; i++) begin
			@(posedge clk);
			desc_ready <= slow ? 1'($urandom % 2) : 1'b1;
			@(negedge clk);
			if (desc_valid && desc_ready) begin
				got.push_back(desc_data);
				done = desc_last;
			end
		end
		@(posedge clk);
		desc_ready <= 1'b0;
	endtask
endmodule

// [tb/hdb_builder_tb.sv]
module hdb_builder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
	logic        upstream_line_plus, upstream_line_minus;
	logic        desc_req, desc_ready, desc_valid, desc_last, desc_busy;
	logic [2:0]  desc_sel;
	logic [7:0]  desc_req_len, desc_data, lb, ls, lm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0]  exp[$];
	logic [7:0]  str[3][30];
	int          err_total, check_count, ln[3];

	hdb_builder #(.STR_MAX(30)) dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .upstream_line_plus, .upstream_line_minus, .desc_req,
		.desc_sel, .desc_req_len, .desc_ready, .desc_valid, .desc_data, .desc_last,
		.desc_busy, .irq);
	hdb_host host (.clk, .desc_valid, .desc_data, .desc_last, .desc_req, .desc_sel,
		.desc_req_len, .desc_ready);

	always #12.5 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Setup cycle, then access until pready; read data taken at that edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic void hub_exp(logic [7:0] c, logic [7:0] m);
		exp = '{8'h09, 8'h29, 8'h00, 8'h00, 8'h00, 8'h00, c, m, 8'hFF};
	endfunction
	function automatic void str_exp(int s);
		exp = '{8'(ln[s] + 2), 8'h03};
		for (int i = 0; i < ln[s]; i++) exp.push_back(str[s][i]);
	endfunction
	// Count is the smaller of request and descriptor length
	task automatic fetch_chk(input logic [2:0] s, input logic [7:0] n, input bit slow);
		int m;
		host.fetch(s, n, slow);
		m = (n < exp.size()) ? n : exp.size();
		chk("count", m, host.got.size());
		for (int i = 0; i < m && i < host.got.size(); i++) begin
			chk("byte", exp[i], host.got[i]);
		end
	endtask
	task automatic lines(input logic v);
		@(posedge clk);
		upstream_line_plus <= v;
		upstream_line_minus <= v;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic conclude;
		$display("Checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h86cc_1287));
		{clk, nrst, psel, penable, pwrite, upstream_line_plus, upstream_line_minus} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		hub_exp(8'h32, 8'h00);
		fetch_chk(3'd0, 8'd255, 0);
		// Both power modes, fast and stalling host
		for (int k = 0; k < 4; k++) begin
			lb = $urandom;
			ls = $urandom;
			lm = $urandom;
			apb(1, 12'h004, {24'h0, lb});
			apb(1, 12'h008, {24'h0, ls});
			apb(1, 12'h00C, {24'h0, lm});
			apb(1, 12'h000, 32'(k % 2));
			hub_exp(k % 2 ? ls : lb, lm);
			fetch_chk(3'd0, 8'd9, k > 1);
		end
		fetch_chk(3'd0, 8'd7, 1);
		apb(0, 12'h01C, 0);
		chk("status", 32'h0000_0002, q);
		apb(0, 12'h01C, 0);
		chk("status", 32'h0000_0000, q);
		apb(0, 12'h030, 0);
		chk("unmapped", 32'h0000_0000, q);
		lb = $urandom;
		ls = $urandom;
		apb(1, 12'h010, {16'h0, ls, lb});
		exp = '{8'h04, 8'h03, lb, ls};
		fetch_chk(3'd1, 8'd255, 1);
		// Longest maker string, random others
		for (int s = 0; s < 3; s++) begin
			ln[s] = s == 0 ? 30 : 1 + $urandom % 30;
			for (int i = 0; i < ln[s]; i++) begin
				str[s][i] = $urandom;
				apb(1, 12'h018, {14'h0, 2'(s), 3'h0, 5'(i), str[s][i]});
			end
		end
		apb(1, 12'h014, {8'h0, 8'(ln[2]), 8'(ln[1]), 8'(ln[0])});
		for (int s = 0; s < 3; s++) begin
			str_exp(s);
			fetch_chk(3'(s + 2), 8'd255, s == 1);
		end
		apb(1, 12'h020, 1);
		apb(1, 12'h024, 1);
		lines(1);
		chk("irq", 1, irq);
		lines(0);
		apb(0, 12'h01C, 0);
		chk("status", 32'h0000_0003, q);
		@(negedge clk);
		chk("irq", 0, irq);
		apb(1, 12'h020, 0);
		lines(1);
		chk("irq masked", 0, irq);
		lines(0);
		// Masked event must still be latched in status
		apb(0, 12'h01C, 0);
		chk("status masked", 32'h0000_0001, q);
		conclude;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude;
	end
endmodule
